//--- mesev_chk_asserts.sv
// Port checker for the mesh stop event select
`timescale 1ns/10ps
module mesev_chk (
  // Clock, reset and APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  // Sources and increment
  input wire [7:0]  ingress_allocations,
  input wire [7:0]  ingress_credit_starve_cycles,
  input wire [7:0]  req_agent0_stage_credit_stall,
  input wire [7:0]  horizontal_deadlock_slot_use,
  input wire [7:0]  horizontal_egress_skip,
  input wire [7:0]  evt_inc
);
  reg  [16:0] ev_q;
  wire        wr_sel = psel && penable && pwrite && paddr == 12'h000;
  wire [7:0]  code = ev_q[7:0];
  wire [7:0]  m = ev_q[15:8];
  wire        on = ev_q[16];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the event select register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ev_q <= 17'h00000;
    else if (wr_sel)
      ev_q <= pwdata[16:0];
  end
  sequence s_off_write;
    wr_sel && !pwdata[16];
  endsequence
  sequence s_quiet;
    evt_inc == 8'h00;
  endsequence
  chk_zero_wait: assert property (pready) else $error("pready low");
  chk_slverr_map: assert property (pslverr == (psel && penable && paddr != 12'h000 &&
    paddr != 12'h004 && paddr != 12'h008)) else $error("pslverr wrong");
  chk_off_silent: assert property (s_off_write |=> ##1 s_quiet) else $error("inc while off");
  chk_alloc_sum: assert property (on && code == 8'hE1 |=>
    evt_inc == $countones($past(m & ingress_allocations))) else $error("alloc inc");
  chk_slot_even: assert property (on && code == 8'hA6 |=>
    evt_inc == $countones($past(m & 8'h55 & horizontal_deadlock_slot_use))) else $error("slot");
  chk_skip_count: assert property (on && code == 8'hA7 |=>
    evt_inc == $countones($past(m & horizontal_egress_skip))) else $error("skip inc");
  chk_starve_any: assert property (on && code == 8'hE3 |=>
    evt_inc == {7'h00, |$past(m & ingress_credit_starve_cycles)}) else $error("starve");
  chk_stall_any: assert property (on && code == 8'hD0 |=>
    evt_inc == {7'h00, |$past(m & req_agent0_stage_credit_stall)}) else $error("stall");
  chk_hibank_none: assert property (on && code[7:4] == 4'hD && code[0] |=> s_quiet)
    else $error("high bank inc");
endmodule
bind mesev_top mesev_chk u_chk (
  .pclk                          (pclk),
  .presetn                       (presetn),
  .psel                          (psel),
  .penable                       (penable),
  .pwrite                        (pwrite),
  .paddr                         (paddr),
  .pwdata                        (pwdata),
  .pready                        (pready),
  .pslverr                       (pslverr),
  .ingress_allocations           (ingress_allocations),
  .ingress_credit_starve_cycles  (ingress_credit_starve_cycles),
  .req_agent0_stage_credit_stall (req_agent0_stage_credit_stall),
  .horizontal_deadlock_slot_use  (horizontal_deadlock_slot_use),
  .horizontal_egress_skip        (horizontal_egress_skip),
  .evt_inc                       (evt_inc)
);

//--- mesev_far.sv
// Far side model: ring stop buffer activity
`timescale 1ns/10ps
module mesev_far (
  // Event sources, eight bits each
  output reg  [71:0] srcs,
  // Fill level per class
  output wire [39:0] fill
);
  // Class i holds i + 1 entries
  assign fill = 40'h41CC520C41;
  initial srcs = 72'h0;
  // One source active at a time
  task put(input integer i, input [7:0] v);
    reg [71:0] s;
    begin
      s = 72'h0;
      s[8 * i +: 8] = v;
      srcs <= s;
    end
  endtask
endmodule

//--- mesev_fill_sum.v
// Masked sum of the per-class ingress fill levels
`timescale 1ns/10ps
`include "mesev_map.vh"
module mesev_fill_sum (
  // Selection and levels
  input  wire [7:0]                   umask,
  input  wire [8*`MESEV_FILL_W-1:0]   fill,
  // Result
  output reg  [7:0]                   total
);
  reg [7:0] eff;
  integer   i;

  always @* begin
    eff = umask;
    // Alternate data credited position folds onto the common one
    eff[`MESEV_M_DAT_CRD] = umask[`MESEV_M_DAT_CRD] | umask[`MESEV_M_DAT_CRD_ALT];
    eff[`MESEV_M_DAT_CRD_ALT] = 1'b0;
    total = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (eff[i]) begin
        total = total + {3'h0, fill[i*`MESEV_FILL_W +: `MESEV_FILL_W]};
      end
    end
  end
endmodule

//--- mesev_map.vh
// Register map, field layout and event codes of the mesh stop event select
`ifndef MESEV_MAP_VH
`define MESEV_MAP_VH

// Register byte offsets
`define MESEV_OFS_EVSEL     12'h000
`define MESEV_OFS_INCR      12'h004
`define MESEV_OFS_STAT      12'h008

// Event select fields
`define MESEV_CODE_LSB      0
`define MESEV_CODE_MSB      7
`define MESEV_UMASK_LSB     8
`define MESEV_UMASK_MSB     15
`define MESEV_EN_BIT        16
`define MESEV_EVSEL_RST     17'h00000

// Status fields
`define MESEV_ST_MATCH      0
`define MESEV_ST_MULTI      1
`define MESEV_ST_HIBANK     2

// Event codes
`define MESEV_EV_FILL       8'hE0
`define MESEV_EV_ALLOC      8'hE1
`define MESEV_EV_STARVE     8'hE3
`define MESEV_EV_STARVE_B   8'hE4
`define MESEV_EV_REQ0_LO    8'hD0
`define MESEV_EV_REQ0_HI    8'hD1
`define MESEV_EV_REQ1_LO    8'hD2
`define MESEV_EV_REQ1_HI    8'hD3
`define MESEV_EV_DAT0_LO    8'hD4
`define MESEV_EV_DAT0_HI    8'hD5
`define MESEV_EV_DAT1_LO    8'hD6
`define MESEV_EV_DAT1_HI    8'hD7
`define MESEV_EV_SLOT       8'hA6
`define MESEV_EV_SKIP       8'hA7

// Unit mask positions of the ring classes
`define MESEV_M_REQ_UNCRD   0
`define MESEV_M_ACK         1
`define MESEV_M_DAT_UNCRD   2
`define MESEV_M_SNOOP       3
`define MESEV_M_REQ_CRD     4
`define MESEV_M_DAT_CRD_ALT 5
`define MESEV_M_DAT_CRD     6
`define MESEV_M_TOP         7
`define MESEV_SLOT_MASK     8'h55

// Fill level width per ring class
`define MESEV_FILL_W        5
`endif

//--- mesev_ring_or.v
// Class folding and OR qualification for credit starvation events
`timescale 1ns/10ps
`include "mesev_map.vh"
module mesev_ring_or (
  // Selection and conditions
  input  wire [7:0] umask,
  input  wire [7:0] cond,
  // Results
  output wire       hit,
  output wire [3:0] classes
);
  wire [7:0] sel;

  // One count per cycle even with both halves of a class set
  assign sel = umask & cond;
  assign hit = |sel;
  // Request, ack (interface vector folded in), data, snoop
  assign classes[0] = umask[`MESEV_M_REQ_UNCRD] | umask[`MESEV_M_REQ_CRD];
  assign classes[1] = umask[`MESEV_M_ACK] | umask[`MESEV_M_TOP];
  assign classes[2] = umask[`MESEV_M_DAT_UNCRD] | umask[`MESEV_M_DAT_CRD]
                    | umask[`MESEV_M_DAT_CRD_ALT];
  assign classes[3] = umask[`MESEV_M_SNOOP];
endmodule

//--- mesev_top.v
// Mesh stop event select: APB registers and per-cycle increment generation
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "mesev_map.vh"
module mesev_top (
  // Clock and reset
  input  wire                       pclk,
  input  wire                       presetn,
  // APB slave
  input  wire                       psel,
  input  wire                       penable,
  input  wire                       pwrite,
  input  wire [11:0]                paddr,
  input  wire [31:0]                pwdata,
  output reg  [31:0]                prdata,
  output wire                       pready,
  output wire                       pslverr,
  // Ingress buffer sources, indexed by unit mask position
  input  wire [7:0]                 ingress_allocations,
  input  wire [8*`MESEV_FILL_W-1:0] ingress_fill_level,
  input  wire [7:0]                 ingress_credit_starve_cycles,
  input  wire [7:0]                 ingress_credit_starve_cycles_b,
  // Egress crossing stage stalls, one bit per stage 0 to 7
  input  wire [7:0]                 req_agent0_stage_credit_stall,
  input  wire [7:0]                 req_agent1_stage_credit_stall,
  input  wire [7:0]                 data_agent0_stage_credit_stall,
  input  wire [7:0]                 data_agent1_stage_credit_stall,
  // Horizontal egress sources, indexed by unit mask position
  input  wire [7:0]                 horizontal_deadlock_slot_use,
  input  wire [7:0]                 horizontal_egress_skip,
  // Increment toward the counter
  output reg  [7:0]                 evt_inc,
  output reg                        evt_match
);
  // Event select register
  reg  [16:0] evsel_q;
  reg  [16:0] evsel_d;
  // Sticky flag for mixed ring classes
  reg         multi_q;
  reg         multi_d;
  reg         hibank_q;
  reg         hibank_d;
  reg  [7:0]  inc_d;
  reg         match_d;
  reg         ingress_evt;
  reg  [31:0] rdata_d;
  reg         hit_map;

  wire [7:0]  code;
  wire [7:0]  umask;
  wire        enable;
  wire        wr_acc;
  wire        rd_setup;
  wire        hit_starve;
  wire        hit_starve_b;
  wire [3:0]  cls_a;
  wire [7:0]  fill_total;
  wire [2:0]  ncls;

  // Population count of a qualified source vector
  function [3:0] pop8;
    input [7:0] v;
    integer k;
    begin
      pop8 = 4'h0;
      for (k = 0; k < 8; k = k + 1) begin
        pop8 = pop8 + {3'h0, v[k]};
      end
    end
  endfunction

  // Number of ring classes present in a folded class vector
  function [2:0] pop4;
    input [3:0] v;
    begin
      pop4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
    end
  endfunction

  // Stall cycle: one count when any selected stage waits
  function [7:0] stage_cycle;
    input [7:0] m;
    input [7:0] stall;
    begin
      stage_cycle = {7'h00, |(m & stall)};
    end
  endfunction

  assign code   = evsel_q[`MESEV_CODE_MSB:`MESEV_CODE_LSB];
  assign umask  = evsel_q[`MESEV_UMASK_MSB:`MESEV_UMASK_LSB];
  assign enable = evsel_q[`MESEV_EN_BIT];

  // Zero wait state slave
  assign pready   = 1'b1;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pslverr  = psel & penable & ~hit_map;

  // Address decode
  always @* begin
    case (paddr)
      `MESEV_OFS_EVSEL: hit_map = 1'b1;
      `MESEV_OFS_INCR:  hit_map = 1'b1;
      `MESEV_OFS_STAT:  hit_map = 1'b1;
      default:          hit_map = 1'b0;
    endcase
  end

  // Starvation qualification for both starvation codes
  mesev_ring_or u_starve (
    .umask   (umask),
    .cond    (ingress_credit_starve_cycles),
    .hit     (hit_starve),
    .classes (cls_a)
  );

  mesev_ring_or u_starve_b (
    .umask   (umask),
    .cond    (ingress_credit_starve_cycles_b),
    .hit     (hit_starve_b),
    .classes ()
  );

  mesev_fill_sum u_fill (
    .umask (umask),
    .fill  (ingress_fill_level),
    .total (fill_total)
  );

  assign ncls = pop4(cls_a);

  // Event source selection and qualification
  always @* begin
    inc_d       = 8'h00;
    match_d     = 1'b1;
    ingress_evt = 1'b0;
    hibank_d    = 1'b0;
    case (code)
      `MESEV_EV_FILL: begin
        inc_d       = fill_total;
        ingress_evt = 1'b1;
      end
      `MESEV_EV_ALLOC: begin
        inc_d       = {4'h0, pop8(umask & ingress_allocations)};
        ingress_evt = 1'b1;
      end
      `MESEV_EV_STARVE: begin
        inc_d       = {7'h00, hit_starve};
        ingress_evt = 1'b1;
      end
      `MESEV_EV_STARVE_B: begin
        inc_d       = {7'h00, hit_starve_b};
        ingress_evt = 1'b1;
      end
      `MESEV_EV_REQ0_LO: begin
        inc_d = stage_cycle(umask, req_agent0_stage_credit_stall);
      end
      `MESEV_EV_REQ1_LO: begin
        inc_d = stage_cycle(umask, req_agent1_stage_credit_stall);
      end
      `MESEV_EV_DAT0_LO: begin
        inc_d = stage_cycle(umask, data_agent0_stage_credit_stall);
      end
      `MESEV_EV_DAT1_LO: begin
        inc_d = stage_cycle(umask, data_agent1_stage_credit_stall);
      end
      `MESEV_EV_REQ0_HI, `MESEV_EV_REQ1_HI, `MESEV_EV_DAT0_HI, `MESEV_EV_DAT1_HI: begin
        // Stages 8 to 10 do not exist here
        inc_d    = 8'h00;
        hibank_d = |umask[2:0];
      end
      `MESEV_EV_SLOT: begin
        inc_d = {4'h0, pop8(umask & `MESEV_SLOT_MASK & horizontal_deadlock_slot_use)};
      end
      `MESEV_EV_SKIP: begin
        inc_d = {4'h0, pop8(umask & horizontal_egress_skip)};
      end
      default: begin
        inc_d   = 8'h00;
        match_d = 1'b0;
      end
    endcase
    if (!enable) begin
      inc_d       = 8'h00;
      match_d     = 1'b0;
      ingress_evt = 1'b0;
      hibank_d    = 1'b0;
    end
  end

  // Register writes; a new mixed selection beats a clear in the same cycle
  always @* begin
    evsel_d = evsel_q;
    multi_d = multi_q;
    if (wr_acc && paddr == `MESEV_OFS_EVSEL) begin
      evsel_d = pwdata[16:0];
    end
    if (wr_acc && paddr == `MESEV_OFS_STAT && pwdata[`MESEV_ST_MULTI]) begin
      multi_d = 1'b0;
    end
    if (ingress_evt && ncls > 3'h1) begin
      multi_d = 1'b1;
    end
  end

  // Read data, captured in the setup phase
  always @* begin
    rdata_d = 32'h00000000;
    case (paddr)
      `MESEV_OFS_EVSEL: rdata_d = {15'h0000, evsel_q};
      `MESEV_OFS_INCR:  rdata_d = {24'h000000, evt_inc};
      `MESEV_OFS_STAT:  rdata_d = {29'h00000000, hibank_q, multi_q, evt_match};
      default:          rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evsel_q   <= `MESEV_EVSEL_RST;
      multi_q   <= 1'b0;
      hibank_q  <= 1'b0;
      evt_inc   <= 8'h00;
      evt_match <= 1'b0;
      prdata    <= 32'h00000000;
    end else begin
      evsel_q   <= evsel_d;
      multi_q   <= multi_d;
      hibank_q  <= hibank_d;
      evt_inc   <= inc_d;
      evt_match <= match_d;
      if (rd_setup) begin
        prdata <= rdata_d;
      end
    end
  end
endmodule

//--- mesh_stop_event_select_test.sv
// Self-checking bench for the mesh stop event select
`timescale 1ns/10ps
module mesh_stop_event_select_test;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [71:0] srcs;
  wire [39:0] fill;
  wire [7:0]  evt_inc;
  wire        evt_match;
  reg  [31:0] rd;
  reg         err;
  integer     failures = 0;
  integer     checks = 0;
  integer     cyc = 0;
  integer     k;
  always #50 pclk = ~pclk;
  mesev_far far (.srcs(srcs), .fill(fill));
  mesev_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ingress_allocations(srcs[7:0]), .ingress_fill_level(fill),
    .ingress_credit_starve_cycles(srcs[15:8]), .ingress_credit_starve_cycles_b(srcs[23:16]),
    .req_agent0_stage_credit_stall(srcs[31:24]), .req_agent1_stage_credit_stall(srcs[39:32]),
    .data_agent0_stage_credit_stall(srcs[47:40]), .data_agent1_stage_credit_stall(srcs[55:48]),
    .horizontal_deadlock_slot_use(srcs[63:56]), .horizontal_egress_skip(srcs[71:64]),
    .evt_inc(evt_inc), .evt_match(evt_match));
  task cmp(input string n, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("unexpected %0s: expected %0h, seen %0h", n, e, g);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Enable one event, drive one source, judge the next increment
  task ev(input [7:0] c, input [7:0] m, input integer i, input [7:0] v, input [7:0] e,
          input mt);
    begin
      apb(1'b1, 12'h000, {15'h0000, 1'b1, m, c});
      far.put(i, v);
      @(posedge pclk);
      #1;
      cmp("evt_inc", {24'h0, e}, {24'h0, evt_inc});
      cmp("evt_match", {31'h0, mt}, {31'h0, evt_match});
    end
  endtask
  task t_regs;
    begin
      apb(1'b0, 12'h000, 32'h0);
      cmp("evsel", 32'h0, rd);
      apb(1'b0, 12'h010, 32'h0);
      cmp("pslverr", 32'h1, {31'h0, err});
      cmp("unmapped", 32'h0, rd);
      apb(1'b1, 12'h000, 32'hFFFFFFFF);
      apb(1'b0, 12'h000, 32'h0);
      cmp("evsel", 32'h0001FFFF, rd);
    end
  endtask
  task t_ingress;
    begin
      ev(8'hE1, 8'h11, 0, 8'h11, 8'h02, 1'b1);
      ev(8'hE1, 8'h44, 0, 8'hFF, 8'h02, 1'b1);
      ev(8'hE1, 8'h80, 0, 8'h80, 8'h01, 1'b1);
      ev(8'hE1, 8'h01, 0, 8'hFE, 8'h00, 1'b1);
      ev(8'hE0, 8'h44, 0, 8'h00, 8'h0A, 1'b1);
      ev(8'hE0, 8'h20, 0, 8'h00, 8'h07, 1'b1);
      ev(8'hE0, 8'h11, 0, 8'h00, 8'h06, 1'b1);
    end
  endtask
  task t_starve;
    begin
      ev(8'hE3, 8'h82, 1, 8'h82, 8'h01, 1'b1);
      ev(8'hE3, 8'h02, 1, 8'h02, 8'h01, 1'b1);
      ev(8'hE4, 8'h80, 2, 8'h80, 8'h01, 1'b1);
      ev(8'hE4, 8'h11, 2, 8'h11, 8'h01, 1'b1);
      ev(8'hE4, 8'h44, 1, 8'hFF, 8'h00, 1'b1);
    end
  endtask
  task t_egress;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        ev(8'(8'hD0 + 2 * k), 8'h80, 3 + k, 8'h80, 8'h01, 1'b1);
        ev(8'(8'hD0 + 2 * k), 8'h01, 3 + k, 8'hFE, 8'h00, 1'b1);
        ev(8'(8'hD1 + 2 * k), 8'h07, 3 + k, 8'hFF, 8'h00, 1'b1);
      end
      ev(8'hA6, 8'hFF, 7, 8'hFF, 8'h04, 1'b1);
      ev(8'hA6, 8'h10, 7, 8'h10, 8'h01, 1'b1);
      ev(8'hA7, 8'hFF, 8, 8'hFF, 8'h08, 1'b1);
      ev(8'hA7, 8'h44, 7, 8'hFF, 8'h00, 1'b1);
    end
  endtask
  // Status flags, increment read back, set beating clear
  task t_stat;
    begin
      apb(1'b1, 12'h000, 32'h000103E1);
      far.put(0, 8'h03);
      apb(1'b0, 12'h008, 32'h0);
      cmp("stat", 32'h3, rd);
      apb(1'b0, 12'h004, 32'h0);
      cmp("incr", 32'h2, rd);
      apb(1'b1, 12'h008, 32'h2);
      apb(1'b0, 12'h008, 32'h0);
      cmp("stat", 32'h3, rd);
      apb(1'b1, 12'h000, 32'h000101E1);
      apb(1'b1, 12'h008, 32'h2);
      apb(1'b0, 12'h008, 32'h0);
      cmp("stat", 32'h1, rd);
      apb(1'b1, 12'h000, 32'h000107D1);
      apb(1'b0, 12'h008, 32'h0);
      cmp("stat", 32'h5, rd);
    end
  endtask
  // Reset in mid-run clears selection and increment
  task t_reset;
    begin
      ev(8'hA7, 8'hFF, 8, 8'hFF, 8'h08, 1'b1);
      presetn <= 1'b0;
      @(posedge pclk);
      #1;
      cmp("evt_inc", 32'h0, {24'h0, evt_inc});
      cmp("evt_match", 32'h0, {31'h0, evt_match});
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      cmp("evsel", 32'h0, rd);
      cmp("evt_inc", 32'h0, {24'h0, evt_inc});
    end
  endtask
  task t_idle;
    begin
      ev(8'h55, 8'hFF, 0, 8'hFF, 8'h00, 1'b0);
      apb(1'b1, 12'h000, 32'h000011E1);
      far.put(0, 8'h11);
      @(posedge pclk);
      #1;
      cmp("evt_inc", 32'h0, {24'h0, evt_inc});
    end
  endtask
  task final_report;
    begin
      if (failures == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_ingress;
    t_starve;
    t_egress;
    t_stat;
    t_reset;
    t_idle;
    final_report;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      final_report;
    end
  end
endmodule
